// ==== hdl/nvb_access.sv ====
/*
 nvb_access: nonvolatile byte store with index, value and control registers.
 holds the 128-byte array, the index and value registers, the control
 register reached through the indirect pointer, a read sequencer that
 counts system clocks and a write sequencer that counts slow-timer ticks,
 and the write-done request flag with its vector qualifier.
 assumes the cpu core drives the write strobes, the indirect pointer
 high byte, and a slow timer tick from an asynchronous oscillator.
 assumes every strobe is a one-cycle pulse synchronous to clk and that
 the slow tick is a free square wave whose every edge is one tick.
 assumes the core clears the done flag through the serviced pulse and
 handles nesting and priority of interrupts itself.
 the store itself has no reset; its contents persist across srst.
 registers read back one cycle after the state they mirror.
*/
// Function
// [RULE_01] store of 128 bytes, accessed byte-wise
// [RULE_02] control decodes at 40h, sector 01h
// [RULE_03] index is 7 bits, bit 7 zero
// [RULE_04] control bit layout; upper bits read zero
// [RULE_05] program trigger ignored without prior permit
// [RULE_06] program trigger self-clears at write end
// [RULE_07] read trigger ignored without prior permit
// [RULE_08] read trigger clears, value then valid
// [RULE_09] value register holds until next operation
// [RULE_10] program permit clear blocks writes
// [RULE_11] read permit clear blocks reads
// [RULE_12] firmware sets permit then trigger consecutively
// [RULE_13] firmware sets one control bit per instruction
// [RULE_14] firmware masks interrupts around write start
// [RULE_15] write timed by asynchronous slow timer
// [RULE_16] firmware ensures slow clock is stable
// [RULE_17] firmware leaves registers alone during write
// [RULE_18] write end sets done flag
// [RULE_19] vector only with both enables, stack free
// [RULE_20] done flag clears when serviced
// [RULE_21] reset clears permit and pointer high
// [RULE_22] firmware reloads index for every read
// [RULE_23] firmware avoids sleep during operations
// [RULE_24] cycle lengths are parameters; trigger held
// [RULE_25] control writes ignored during write cycle
`timescale 1ns/1ps
`default_nettype none
module nvb_access
   import nvb_pkg::*;
#(
   parameter int READ_CYCLES = NVB_READ_CYCLES,
   parameter int WRITE_TICKS = NVB_WRITE_TICKS
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic indexWrite,
   input wire logic valueWrite,
   input wire logic pointerLowWrite,
   input wire logic pointerHighWrite,
   input wire logic indirectWrite,
   input wire logic [7:0] cpuWriteData,
   input wire logic slowTick,
   input wire logic global_irq_enable,
   input wire logic nv_done_irq_enable,
   input wire logic stackFull,
   input wire logic irqServiced,
   output logic [7:0] nv_byte_index,
   output logic [7:0] nv_byte_value,
   output logic [7:0] nv_control,
   output logic [7:0] pointer1_low,
   output logic [7:0] pointer1_high,
   output logic nv_done_irq_flag,
   output logic irqVector
);
   // one-hot sequencer states
   typedef enum logic [2:0] {
      NVB_IDLE = 3'b001,
      NVB_READ = 3'b010,
      NVB_WRITE = 3'b100
   } nvb_state_e;

   // storage and sequencing
   logic [NVB_DW-1:0] store [NVB_DEPTH];
   nvb_state_e state;
   logic [NVB_CNT_W-1:0] count;
   logic isIdle;
   logic isReading;
   logic isWriting;

   // register image
   logic [NVB_AW-1:0] index;
   logic progPermit;
   logic progTrig;
   logic readPermit;
   logic readTrig;

   // slow timer crossing
   logic [2:0] tickSync;
   logic tickEdge;

   // decode and events
   logic ctrlSel;
   logic ctrlWrite;
   logic startWrite;
   logic startRead;
   logic readDone;
   logic writeDone;

   assign isIdle = (state == NVB_IDLE);
   assign isReading = (state == NVB_READ);
   assign isWriting = (state == NVB_WRITE);
   // control decodes only at its offset in sector 1
   assign ctrlSel = (pointer1_low == NVB_CTRL_OFFSET)
                    && (pointer1_high == NVB_CTRL_SECTOR); // [RULE_02]
   // a running write shields the control register
   assign ctrlWrite = indirectWrite && ctrlSel && !isWriting; // [RULE_25]
   // trigger acts only on a permit already held
   assign startWrite = ctrlWrite
                       && cpuWriteData[NVB_BIT_PROG_TRIG]
                       && progPermit
                       && isIdle; // [RULE_05] [RULE_10]
   assign startRead = ctrlWrite
                      && cpuWriteData[NVB_BIT_READ_TRIG]
                      && readPermit
                      && isIdle
                      && !startWrite; // [RULE_07] [RULE_11]
   // each toggle of the slow clock is one timer tick
   assign tickEdge = tickSync[1] ^ tickSync[2]; // [RULE_15]
   assign readDone = isReading && (count == NVB_CNT_ONE);
   assign writeDone = isWriting
                      && tickEdge
                      && (count == NVB_CNT_ONE);

   // slow tick synchroniser; stage 0 feeds stage 1 only
   always_ff @(posedge clk) begin
      if (srst) begin
         tickSync <= NVB_SYNC_ZERO;
      end else begin
         tickSync <= {tickSync[1:0], slowTick};
      end
   end

   // pointer low byte selects the register within a sector
   always_ff @(posedge clk) begin
      if (srst) begin
         pointer1_low <= NVB_RESET_BYTE;
      end else if (pointerLowWrite) begin
         pointer1_low <= cpuWriteData;
      end
   end

   // sector 0 after reset keeps the control register out of reach
   always_ff @(posedge clk) begin
      if (srst) begin
         pointer1_high <= NVB_RESET_BYTE; // [RULE_21]
      end else if (pointerHighWrite) begin
         pointer1_high <= cpuWriteData;
      end
   end

   // index register; bit 7 is not implemented
   always_ff @(posedge clk) begin
      if (srst) begin
         index <= NVB_RESET_INDEX; // [RULE_03]
      end else if (indexWrite) begin
         index <= cpuWriteData[NVB_AW-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state <= NVB_IDLE;
      end else begin
         unique case (state)
            NVB_IDLE: begin
               if (startWrite) begin
                  state <= NVB_WRITE;
               end else if (startRead) begin
                  state <= NVB_READ;
               end
            end
            NVB_READ: begin
               if (readDone) begin
                  state <= NVB_IDLE;
               end
            end
            NVB_WRITE: begin
               if (writeDone) begin
                  state <= NVB_IDLE;
               end
            end
         endcase
      end
   end

   // cycle counter: reads count clocks, writes count slow ticks
   always_ff @(posedge clk) begin
      if (srst) begin
         count <= NVB_CNT_ZERO;
      end else if (startWrite) begin
         count <= NVB_CNT_W'(WRITE_TICKS); // [RULE_24]
      end else if (startRead) begin
         count <= NVB_CNT_W'(READ_CYCLES); // [RULE_24]
      end else if (isReading && !readDone) begin
         count <= count - NVB_CNT_ONE;
      end else if (isWriting && tickEdge && !writeDone) begin
         count <= count - NVB_CNT_ONE; // [RULE_15]
      end
   end

   // permit bits follow every accepted control write
   always_ff @(posedge clk) begin
      if (srst) begin
         progPermit <= 1'b0; // [RULE_21] [RULE_04]
      end else if (ctrlWrite) begin
         progPermit <= cpuWriteData[NVB_BIT_PROG_PERMIT];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         readPermit <= 1'b0; // [RULE_04]
      end else if (ctrlWrite) begin
         readPermit <= cpuWriteData[NVB_BIT_READ_PERMIT];
      end
   end

   // program trigger stays set for the whole write cycle
   always_ff @(posedge clk) begin
      if (srst) begin
         progTrig <= 1'b0;
      end else if (writeDone) begin
         progTrig <= 1'b0; // [RULE_06]
      end else if (startWrite) begin
         progTrig <= 1'b1; // [RULE_24]
      end
   end

   // read trigger; a zero written while idle drops it as well
   always_ff @(posedge clk) begin
      if (srst) begin
         readTrig <= 1'b0;
      end else if (readDone) begin
         readTrig <= 1'b0; // [RULE_08]
      end else if (startRead) begin
         readTrig <= 1'b1; // [RULE_24]
      end else if (ctrlWrite && !cpuWriteData[NVB_BIT_READ_TRIG] && isIdle) begin
         readTrig <= 1'b0;
      end
   end

   // one byte committed at the end of the write timer
   always_ff @(posedge clk) begin
      if (writeDone) begin
         store[index] <= nv_byte_value; // [RULE_01]
      end
   end

   // value register: cpu write, or the byte fetched by a read
   always_ff @(posedge clk) begin
      if (srst) begin
         nv_byte_value <= NVB_RESET_BYTE;
      end else if (readDone) begin
         nv_byte_value <= store[index]; // [RULE_08] [RULE_09]
      end else if (valueWrite && state != NVB_WRITE) begin
         nv_byte_value <= cpuWriteData;
      end
   end

   // done flag: a new write end wins over servicing
   always_ff @(posedge clk) begin
      if (srst) begin
         nv_done_irq_flag <= 1'b0;
      end else if (writeDone) begin
         nv_done_irq_flag <= 1'b1; // [RULE_18]
      end else if (irqServiced) begin
         nv_done_irq_flag <= 1'b0; // [RULE_20]
      end
   end

   // vector request; the service pulse masks it at once
   always_ff @(posedge clk) begin
      if (srst) begin
         irqVector <= 1'b0;
      end else begin
         irqVector <= nv_done_irq_flag
                      && global_irq_enable && nv_done_irq_enable
                      && !stackFull && !irqServiced; // [RULE_19]
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         nv_byte_index <= NVB_RESET_BYTE;
      end else begin
         nv_byte_index <= {1'b0, index}; // [RULE_03]
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         nv_control <= NVB_RESET_BYTE;
      end else begin
         nv_control <= {4'h0, progPermit, progTrig, readPermit, readTrig}; // [RULE_04]
      end
   end
endmodule
`default_nettype wire

// ==== shared/nvb_pkg.sv ====
/*
 nvb_pkg: constants for the byte-wide nonvolatile store access block.
 assumes one system clock; all values named here, none in the logic.
*/
package nvb_pkg;
   localparam int NVB_DEPTH = 128;
   localparam int NVB_AW = 7;
   localparam int NVB_DW = 8;
   localparam logic [7:0] NVB_CTRL_OFFSET = 8'h40;
   localparam logic [7:0] NVB_CTRL_SECTOR = 8'h01;
   localparam logic [7:0] NVB_RESET_BYTE = 8'h00;
   localparam logic [6:0] NVB_RESET_INDEX = 7'h00;
   localparam int NVB_BIT_PROG_PERMIT = 3;
   localparam int NVB_BIT_PROG_TRIG = 2;
   localparam int NVB_BIT_READ_PERMIT = 1;
   localparam int NVB_BIT_READ_TRIG = 0;
   localparam int NVB_READ_CYCLES = 4;
   localparam int NVB_WRITE_TICKS = 4;
   localparam int NVB_CNT_W = 16;
   localparam logic [15:0] NVB_CNT_ONE = 16'h0001;
   localparam logic [15:0] NVB_CNT_ZERO = 16'h0000;
   localparam logic [2:0] NVB_SYNC_ZERO = 3'h0;
endpackage

// ==== sim/nvb_chk.sv ====
/* nvb_chk: port-level assertions for nvb_access.
   assumes it is bound into nvb_access; one clock, srst sync high. */
`timescale 1ns/1ps
`default_nettype none
module nvb_chk (
   input wire logic clk,
   input wire logic srst,
   input wire logic indirectWrite,
   input wire logic valueWrite,
   input wire logic irqServiced,
   input wire logic global_irq_enable,
   input wire logic nv_done_irq_enable,
   input wire logic stackFull,
   input wire logic [7:0] cpuWriteData,
   input wire logic [7:0] nv_byte_index,
   input wire logic [7:0] nv_byte_value,
   input wire logic [7:0] nv_control,
   input wire logic [7:0] pointer1_low,
   input wire logic [7:0] pointer1_high,
   input wire logic nv_done_irq_flag,
   input wire logic irqVector
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   logic hit;
   assign hit = indirectWrite && pointer1_low == 8'h40 && pointer1_high == 8'h01;
   sequence s_rd_busy;
      nv_control[0] [*3] ##[1:4] !nv_control[0];
   endsequence
   property p_pad_zero;
      nv_control[7:4] == 4'h0 && !nv_byte_index[7];
   endproperty
   a_pad_zero: assert property (p_pad_zero)
      else $error("pad bits set");
   property p_wr_refused;
      hit && cpuWriteData == 8'h04 && nv_control == 8'h00 && !$past(hit) |=> (!nv_control[2]) [*3];
   endproperty
   a_wr_refused: assert property (p_wr_refused)
      else $error("trigger without permit");
   property p_wr_hold;
      $rose(nv_control[2]) |-> nv_control[2] [*8];
   endproperty
   a_wr_hold: assert property (p_wr_hold)
      else $error("write ended too soon");
   property p_rd_cycle;
      $rose(nv_control[0]) |-> s_rd_busy;
   endproperty
   a_rd_cycle: assert property (p_rd_cycle)
      else $error("read cycle length");
   property p_done;
      $fell(nv_control[2]) |-> nv_done_irq_flag;
   endproperty
   a_done: assert property (p_done)
      else $error("no done flag");
   property p_value_hold;
      $changed(nv_byte_value) && !$past(valueWrite) |-> ##1 $fell(nv_control[0]);
   endproperty
   a_value_hold: assert property (p_value_hold)
      else $error("value changed");
   property p_vector;
      irqVector == $past(nv_done_irq_flag && global_irq_enable && nv_done_irq_enable
         && !stackFull && !irqServiced);
   endproperty
   a_vector: assert property (p_vector)
      else $error("vector mismatch");
   property p_service;
      irqServiced && !nv_control[2] |=> !nv_done_irq_flag;
   endproperty
   a_service: assert property (p_service)
      else $error("flag not cleared");
endmodule
`default_nettype wire

// ==== sim/nvb_slow_osc.sv ====
/* nvb_slow_osc: free-running slow oscillator for the write timer.
   assumes nothing of the system clock; its period is unrelated. */
`timescale 1ns/1ps
`default_nettype none
module nvb_slow_osc (
   output logic slowTick
);
   initial slowTick = 1'b0;
   always #37 slowTick = ~slowTick;
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
/* testbench: firmware-style register sequences against nvb_access.
   assumes the slow oscillator model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
bind nvb_access nvb_chk CHK (.*);
module testbench;
   logic clk = 1'b0, srst = 1'b1, gie = 1'b0, lie = 1'b0, svc = 1'b0, slowTick, flag, vec;
   logic sf = 1'b0;
   logic [4:0] stb = 5'h00;
   logic [7:0] d = 8'h00, idx, val, ctl, pl, ph;
   int n_fail = 0, n_checks = 0, cyc = 0;
   always #4 clk = ~clk;
   nvb_slow_osc PARTNER (.slowTick(slowTick));
   nvb_access DUT (.clk(clk), .srst(srst), .indexWrite(stb[0]), .valueWrite(stb[1]),
      .pointerLowWrite(stb[2]), .pointerHighWrite(stb[3]), .indirectWrite(stb[4]),
      .cpuWriteData(d), .slowTick(slowTick), .global_irq_enable(gie),
      .nv_done_irq_enable(lie), .stackFull(sf), .irqServiced(svc), .nv_byte_index(idx),
      .nv_byte_value(val), .nv_control(ctl), .pointer1_low(pl), .pointer1_high(ph),
      .nv_done_irq_flag(flag), .irqVector(vec));
   task automatic end_of_test();
      if (n_fail == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   // one strobe per instruction, back to back
   task automatic wr(input int i, input logic [7:0] v);
      @(posedge clk);
      #1 stb = 5'h01 << i;
      d = v;
   endtask
   task automatic idle(input int n);
      repeat (n) begin
         @(posedge clk);
         #1 stb = 5'h00;
      end
   endtask
   task automatic wait_clear(input int b);
      idle(2);
      while (ctl[b] !== 1'b0) idle(1);
   endtask
   task automatic t_write(input logic [7:0] a, input logic [7:0] v);
      wr(0, a);
      wr(1, v);
      wr(2, 8'h40);
      wr(3, 8'h01);
      wr(4, 8'h08);
      wr(4, 8'h0c);
      wr(4, 8'h00);
      idle(3);
      chk(ctl, 8'h0c);
      wait_clear(2);
      chk(ctl, 8'h08);
      chk({7'h00, flag}, 8'h01);
   endtask
   task automatic t_read(input logic [7:0] a, input logic [7:0] v);
      wr(0, a);
      wr(4, 8'h02);
      wr(4, 8'h03);
      wait_clear(0);
      chk(val, v);
      chk(ctl, 8'h02);
      wr(0, a ^ 8'h01);
      idle(3);
      chk(val, v);
   endtask
   task automatic t_refuse();
      wr(4, 8'h00);
      idle(2);
      wr(4, 8'h04);
      idle(3);
      chk(ctl, 8'h00);
      wr(4, 8'h01);
      idle(3);
      chk(ctl, 8'h00);
      wr(2, 8'h41);
      wr(4, 8'h08);
      idle(3);
      chk(ctl, 8'h00);
      chk(pl, 8'h41);
      wr(0, 8'hff);
      idle(2);
      chk(idx, 8'h7f);
   endtask
   task automatic t_service();
      @(posedge clk);
      #1 svc = 1'b1;
      @(posedge clk);
      #1 svc = 1'b0;
      idle(2);
      chk({6'h00, flag, vec}, 8'h00);
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 6000) begin
         n_fail++;
         end_of_test();
      end
   end
   initial begin
      repeat (8) @(posedge clk);
      #1 srst = 1'b0;
      chk(idx, 8'h00);
      chk(ctl, 8'h00);
      chk(val, 8'h00);
      chk(ph, 8'h00);
      chk(pl, 8'h00);
      t_write(8'h7f, 8'ha5);
      chk({7'h00, vec}, 8'h00);
      t_service();
      t_read(8'h7f, 8'ha5);
      gie = 1'b1;
      lie = 1'b1;
      t_write(8'h00, 8'h3c);
      idle(2);
      chk({7'h00, vec}, 8'h01);
      sf = 1'b1;
      idle(2);
      chk({7'h00, vec}, 8'h00);
      sf = 1'b0;
      idle(2);
      chk({7'h00, vec}, 8'h01);
      t_service();
      t_read(8'h00, 8'h3c);
      t_read(8'h7f, 8'ha5);
      t_refuse();
      end_of_test();
   end
endmodule
`default_nettype wire
